// ===== umsa_pkg.sv
// constants, state type and register map of the modem status and rate detect slice
//
// What this block does
// - modem_line_status is read-only; any read clears change flags 3:0.
// - modem levels and change flags never touch serial transmit or receive.
// - bit 0 sets on any clear-to-send change, holds until status read.
// - bit 1 sets on any data-set-ready change, holds until status read.
// - bit 2 sets only on ring input low-to-high, holds until status read.
// - bit 3 sets on any carrier-detect change, holds until status read.
// - bit 4 shows inverted clear-to-send; loopback takes modem control bit 1.
// - bit 5 shows inverted data-set-ready; loopback takes modem control bit 0.
// - bit 6 shows inverted ring input; loopback takes modem control bit 2.
// - bit 7 shows inverted carrier detect; loopback takes modem control bit 3.
// - scratch_byte is a free 8-bit read/write byte, reset zero, no effect.
// - scratch accesses raise or record no interrupt or indication.
// - rate_detect_control is read/write; every defined field resets to zero.
// - writing 1 to bit 0 starts measurement; hardware clears it when done.
// - the run bit reads 1 while measuring, 0 when stopped or finished.
// - with bit 2 set, time-out restarts counting at next receive falling edge.
// - writing 1 to bit 8 clears the end-of-measurement interrupt.
// - writing 1 to bit 9 clears the time-out interrupt.
// - mode 0 measures fall to fall; mode 1 measures fall to rise.
// - time-out is counter overflow; flagged when its enable is set.
// - on success counter loads divisor pair, then done interrupt if enabled.
package umsa_pkg;

  localparam int          ADDR_W         = 32;
  localparam int          DATA_W         = 32;
  localparam int          CNT_W          = 16;
  localparam int          PRE_W          = 4;

  localparam logic [31:0] MSR_ADDR       = 32'h4000_8018;
  localparam logic [31:0] SCR_ADDR       = 32'h4000_801c;
  localparam logic [31:0] ACR_ADDR       = 32'h4000_8020;

  localparam int          MSR_CTS_CHG_BIT   = 0;
  localparam int          MSR_DSR_CHG_BIT   = 1;
  localparam int          MSR_RING_EDGE_BIT = 2;
  localparam int          MSR_DCD_CHG_BIT   = 3;
  localparam int          MSR_LVL_LSB    = 4;
  localparam int          MSR_FLAGS_W    = 4;

  localparam int          MCR_DTR_BIT    = 0;
  localparam int          MCR_RTS_BIT    = 1;
  localparam int          MCR_OUT1_BIT   = 2;
  localparam int          MCR_OUT2_BIT   = 3;

  localparam int          SCR_W          = 8;
  localparam logic [7:0]  SCR_RESET      = 8'h00;

  localparam int          ACR_START_BIT  = 0;
  localparam int          ACR_MODE_BIT   = 1;
  localparam int          ACR_RESTART_BIT = 2;
  localparam int          ACR_DONECLR_BIT = 8;
  localparam int          ACR_TOCLR_BIT  = 9;

  // last prescale count; the counter advances once per this many plus one (16) peripheral clocks
  localparam logic [3:0]  PRE_LAST       = 4'hf;
  localparam logic [15:0] CNT_MAX        = 16'hffff;
  localparam logic [15:0] CNT_ZERO       = 16'h0000;

  typedef enum logic [1:0] {
    UMSA_IDLE,
    UMSA_ARMED,
    UMSA_MEASURE
  } umsa_state_t;

endpackage : umsa_pkg

// ===== umsa_sync.sv
// two-stage synchroniser for pin levels
`timescale 1ns/1ps
module umsa_sync #(
  parameter int             WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_r;

  // the first stage is only ever read by the second
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      stage1_r <= RESET_VAL;
      syncOut  <= RESET_VAL;
    end
    else
    begin
      stage1_r <= pinIn;
      syncOut  <= stage1_r;
    end
  end

endmodule : umsa_sync

// ===== umsa_top.sv
// modem status, scratch byte and rate detect control with its measuring counter
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
module umsa_top
  import umsa_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic              wrStb,
  input  wire logic              rdStb,
  output logic      [DATA_W-1:0] rdData,
  input  wire logic              clearToSendN,
  input  wire logic              setReadyN,
  input  wire logic              ringN,
  input  wire logic              carrierN,
  input  wire logic              rxd,
  input  wire logic              modemLoopback,
  input  wire logic [3:0]        modemLineControl,
  input  wire logic              rateDoneIrqEn,
  input  wire logic              rateTimeoutIrqEn,
  output logic                   rateDoneIrq,
  output logic                   rateTimeoutIrq,
  output logic [7:0]             divisorHigh,
  output logic [7:0]             divisorLow,
  output logic                   divisorLoad,
  output logic                   rateMeasuring
);

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [31:0] base);
    hit = (a == base);
  endfunction : hit

  // pins are active low and idle high, so the synchronisers reset high
  logic [3:0]   modemSync;
  logic         rxdSync;
  logic         rxdPrev_r;
  logic         rxdFall;
  logic         rxdRise;

  logic [3:0]   modemLevel_r;
  logic [3:0]   modemLevel_nxt;
  logic [3:0]   changeFlags_r;
  logic [3:0]   changeSet;
  logic [7:0]   scratch_r;
  logic         runBit_r;
  logic         mode_r;
  logic         restart_r;

  umsa_state_t  state_r;
  umsa_state_t  state_nxt;
  logic [PRE_W-1:0] pre_r;
  logic [CNT_W-1:0] cnt_r;
  logic         tick;
  logic         overflow;
  logic         measureEnd;

  logic         msrRead;
  logic         scrWrite;
  logic         acrWrite;
  logic         startReq;
  logic         stopReq;
  logic [DATA_W-1:0] readMux;

  umsa_sync #(
    .WIDTH     (5),
    .RESET_VAL (5'h1f)
  ) u_sync (
    .mclk    (mclk),
    .rst     (rst),
    .pinIn   ({rxd, carrierN, ringN, setReadyN, clearToSendN}),
    .syncOut ({rxdSync, modemSync})
  );

  assign msrRead  = rdStb && hit(addr, MSR_ADDR);
  assign scrWrite = wrStb && hit(addr, SCR_ADDR);
  assign acrWrite = wrStb && hit(addr, ACR_ADDR);
  assign startReq = acrWrite && wrData[ACR_START_BIT];
  assign stopReq  = acrWrite && !wrData[ACR_START_BIT];

  // level order in modemLevel: 0 cts, 1 dsr, 2 ri, 3 dcd
  always_comb
  begin
    if (modemLoopback)
    begin
      modemLevel_nxt[0] = modemLineControl[MCR_RTS_BIT];
      modemLevel_nxt[1] = modemLineControl[MCR_DTR_BIT];
      modemLevel_nxt[2] = modemLineControl[MCR_OUT1_BIT];
      modemLevel_nxt[3] = modemLineControl[MCR_OUT2_BIT];
    end
    else
    begin
      modemLevel_nxt = ~modemSync;
    end
  end

  always_comb
  begin
    changeSet = modemLevel_nxt ^ modemLevel_r;
    changeSet[MSR_RING_EDGE_BIT] = modemLevel_r[2] && !modemLevel_nxt[2];
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      modemLevel_r <= 4'h0;
    end
    else
    begin
      modemLevel_r <= modemLevel_nxt;
    end
  end

  // a change in the same cycle as the clearing read survives the read
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      changeFlags_r <= 4'h0;
    end
    else if (msrRead)
    begin
      changeFlags_r <= changeSet;
    end
    else
    begin
      changeFlags_r <= changeFlags_r | changeSet;
    end
  end

  // scratch feeds nothing but the read path
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      scratch_r <= SCR_RESET;
    end
    else if (scrWrite)
    begin
      scratch_r <= wrData[SCR_W-1:0];
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      mode_r    <= 1'b0;
      restart_r <= 1'b0;
    end
    else if (acrWrite)
    begin
      mode_r    <= wrData[ACR_MODE_BIT];
      restart_r <= wrData[ACR_RESTART_BIT];
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rxdPrev_r <= 1'b1;
    end
    else
    begin
      rxdPrev_r <= rxdSync;
    end
  end

  assign rxdFall = rxdPrev_r && !rxdSync;
  assign rxdRise = !rxdPrev_r && rxdSync;

  assign tick       = (state_r == UMSA_MEASURE) && (pre_r == PRE_LAST);
  assign overflow   = tick && (cnt_r == CNT_MAX);
  // mode 0 ends on the next falling edge, mode 1 on the next rising edge
  assign measureEnd = (state_r == UMSA_MEASURE) && !overflow &&
                      (mode_r ? rxdRise : rxdFall);

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      UMSA_IDLE:
      begin
        state_nxt = UMSA_IDLE;
      end
      UMSA_ARMED:
      begin
        if (rxdFall)
        begin
          state_nxt = UMSA_MEASURE;
        end
      end
      UMSA_MEASURE:
      begin
        if (overflow)
        begin
          state_nxt = restart_r ? UMSA_ARMED : UMSA_IDLE;
        end
        else if (measureEnd)
        begin
          state_nxt = UMSA_IDLE;
        end
      end
    endcase
    // a software write always overrides the engine
    if (startReq)
    begin
      state_nxt = UMSA_ARMED;
    end
    else if (stopReq)
    begin
      state_nxt = UMSA_IDLE;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= UMSA_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      runBit_r      <= 1'b0;
      rateMeasuring <= 1'b0;
    end
    else
    begin
      runBit_r      <= (state_nxt != UMSA_IDLE);
      rateMeasuring <= (state_nxt == UMSA_MEASURE);
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pre_r <= '0;
    end
    else if (state_r != UMSA_MEASURE)
    begin
      pre_r <= '0;
    end
    else
    begin
      pre_r <= pre_r + 4'h1;
    end
  end

  // counter is cleared while armed so a restart begins from zero
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= CNT_ZERO;
    end
    else if (state_r != UMSA_MEASURE)
    begin
      cnt_r <= CNT_ZERO;
    end
    else if (tick)
    begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      divisorHigh <= 8'h00;
      divisorLow  <= 8'h00;
      divisorLoad <= 1'b0;
    end
    else
    begin
      divisorLoad <= measureEnd && !startReq && !stopReq;
      if (measureEnd && !startReq && !stopReq)
      begin
        divisorHigh <= cnt_r[15:8];
        divisorLow  <= cnt_r[7:0];
      end
    end
  end

  // the done flag sets one cycle after the divisor load, set beats clear
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rateDoneIrq <= 1'b0;
    end
    else if (divisorLoad && rateDoneIrqEn)
    begin
      rateDoneIrq <= 1'b1;
    end
    else if (acrWrite && wrData[ACR_DONECLR_BIT])
    begin
      rateDoneIrq <= 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rateTimeoutIrq <= 1'b0;
    end
    else if (overflow && rateTimeoutIrqEn)
    begin
      rateTimeoutIrq <= 1'b1;
    end
    else if (acrWrite && wrData[ACR_TOCLR_BIT])
    begin
      rateTimeoutIrq <= 1'b0;
    end
  end

  // clear bits and reserved bits read zero; levels never reach tx or rx
  always_comb
  begin
    readMux = '0;
    if (hit(addr, MSR_ADDR))
    begin
      readMux[MSR_FLAGS_W-1:0]         = changeFlags_r;
      readMux[MSR_LVL_LSB+:MSR_FLAGS_W] = modemLevel_r;
    end
    else if (hit(addr, SCR_ADDR))
    begin
      readMux[SCR_W-1:0] = scratch_r;
    end
    else if (hit(addr, ACR_ADDR))
    begin
      readMux[ACR_START_BIT]   = runBit_r;
      readMux[ACR_MODE_BIT]    = mode_r;
      readMux[ACR_RESTART_BIT] = restart_r;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rdData <= '0;
    end
    else if (rdStb)
    begin
      rdData <= readMux;
    end
    else
    begin
      rdData <= '0;
    end
  end

endmodule : umsa_top

// ===== umsa_checker.sv
// port assertions for the modem status and rate detect slice
`timescale 1ns/1ps
module umsa_checker
  import umsa_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [31:0] addr,
  input wire logic [31:0] wrData,
  input wire logic        wrStb,
  input wire logic        rdStb,
  input wire logic [31:0] rdData,
  input wire logic        rateDoneIrqEn,
  input wire logic        rateDoneIrq,
  input wire logic [7:0]  divisorHigh,
  input wire logic [7:0]  divisorLow,
  input wire logic        divisorLoad
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_rd_idle_zero: assert property (!$past(rdStb) |-> rdData == '0)
    else $error("read data not idle");
  a_ctl_rsv_zero: assert property ($past(rdStb) && $past(addr) == ACR_ADDR
    |-> rdData[31:3] == '0) else $error("control spare bits set");
  a_load_one_pulse: assert property (divisorLoad |=> !divisorLoad)
    else $error("load pulse too long");
  a_done_after_load: assert property (divisorLoad && rateDoneIrqEn |=> rateDoneIrq)
    else $error("done flag missing");
  a_done_has_cause: assert property ($rose(rateDoneIrq) |-> $past(divisorLoad))
    else $error("done flag without load");
  a_done_clears: assert property (wrStb && addr == ACR_ADDR
    && wrData[ACR_DONECLR_BIT] && !divisorLoad |=> !rateDoneIrq) else $error("done flag kept");
  a_div_held: assert property (!divisorLoad |-> $stable({divisorHigh, divisorLow}))
    else $error("divisor moved");
  a_scr_quiet: assert property ((wrStb || rdStb) && addr == SCR_ADDR
    && !divisorLoad |=> rateDoneIrq == $past(rateDoneIrq)) else $error("scratch moved flag");
  c_status_read: cover property (rdStb && addr == MSR_ADDR);
  c_load: cover property (divisorLoad);
  c_done_clear: cover property (rateDoneIrq ##1 !rateDoneIrq);
endmodule : umsa_checker
bind umsa_top umsa_checker umsa_checker_inst (.mclk, .rst, .addr, .wrData, .wrStb,
  .rdStb, .rdData, .rateDoneIrqEn, .rateDoneIrq, .divisorHigh, .divisorLow, .divisorLoad);

// ===== umsa_modem_model.sv
// far side: modem handshake pins and serial receive line
`timescale 1ns/1ps
module umsa_modem_model (
  input  wire logic mclk,
  output logic      clearToSendN,
  output logic      setReadyN,
  output logic      ringN,
  output logic      carrierN,
  output logic      rxd
);
  initial
  begin
    {carrierN, ringN, setReadyN, clearToSendN} = 4'hf;
    rxd = 1'b1;
  end
  // active mask: bit0 cts, bit1 dsr, bit2 ri, bit3 dcd
  task set_pins(input logic [3:0] act);
    @(posedge mclk);
    {carrierN, ringN, setReadyN, clearToSendN} <= ~act;
  endtask : set_pins
  // low start bit; nonzero highLen adds a second low bit after it
  task rx_pulse(input int lowLen, input int highLen);
    @(posedge mclk);
    rxd <= 1'b0;
    repeat (lowLen) @(posedge mclk);
    rxd <= 1'b1;
    if (highLen > 0)
    begin
      repeat (highLen) @(posedge mclk);
      rxd <= 1'b0;
      repeat (lowLen) @(posedge mclk);
      rxd <= 1'b1;
    end
  endtask : rx_pulse
endmodule : umsa_modem_model

// ===== umsa_tb.sv
// self-checking bench for the modem status, scratch and rate detect slice
`timescale 1ns/1ps
module testbench
  import umsa_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] addr = '0;
  logic [31:0] wrData = '0;
  logic        wrStb = 1'b0;
  logic        rdStb = 1'b0;
  logic        modemLoopback = 1'b0;
  logic [3:0]  modemLineControl = '0;
  logic        rateDoneIrqEn = 1'b1;
  logic        rateTimeoutIrqEn = 1'b1;
  logic [31:0] rdData, d;
  logic        clearToSendN, setReadyN, ringN, carrierN, rxd;
  logic        rateDoneIrq, rateTimeoutIrq, divisorLoad, rateMeasuring;
  logic [7:0]  divisorHigh, divisorLow;
  logic [31:0] seed = 32'h283b27a1;
  logic [3:0]  lvl = '0;
  logic [3:0]  flg = '0;
  int          failures = 0;
  int          nChecks = 0;
  int          i;
  always #12.5 mclk = ~mclk;
  umsa_top umsa_top_inst (.mclk, .rst, .addr, .wrData, .wrStb, .rdStb, .rdData,
    .clearToSendN, .setReadyN, .ringN, .carrierN, .rxd, .modemLoopback, .modemLineControl,
    .rateDoneIrqEn, .rateTimeoutIrqEn, .rateDoneIrq, .rateTimeoutIrq, .divisorHigh,
    .divisorLow, .divisorLoad, .rateMeasuring);
  umsa_modem_model umsa_modem_model_inst (.mclk, .clearToSendN, .setReadyN, .ringN,
    .carrierN, .rxd);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    nChecks++;
    if (s !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    @(posedge mclk);
    addr <= a;
    wrData <= v;
    wrStb <= 1'b1;
    @(posedge mclk);
    wrStb <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a);
    @(posedge mclk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge mclk);
    rdStb <= 1'b0;
    @(negedge mclk);
    d = rdData;
  endtask : rd
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // ring flag only when the level drops, the others on any change
  task automatic upd(input logic [3:0] nl);
    flg = flg | ((lvl ^ nl) & 4'hb) | (lvl & ~nl & 4'h4);
    lvl = nl;
  endtask : upd
  task automatic report_and_stop;
    $display("checks %0d failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  // prescale phase may shift the count by one
  task automatic wait_div(input int lim);
    int k;
    int v;
    for (k = 0; k < lim && divisorLoad !== 1'b1; k++)
      @(negedge mclk);
    if (k == lim)
    begin
      failures++;
      report_and_stop();
    end
    else
    begin
      v = {divisorHigh, divisorLow};
      chk("divisor", 32'd300, (v > 298 && v < 302) ? 32'd300 : v);
    end
  endtask : wait_div
  initial
  begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    for (i = 0; i < 4; i++)
    begin
      rd(MSR_ADDR + 32'(i * 4));
      chk("reset value", 32'h0, d);
    end
    for (i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      wr(SCR_ADDR, seed);
      rd(SCR_ADDR);
      chk("scratch", {24'h0, seed[7:0]}, {24'h0, d[7:0]});
      chk("irq flags", 32'h0, {30'h0, rateDoneIrq, rateTimeoutIrq});
    end
    for (i = 0; i < 14; i++)
    begin
      seed = lfsr(seed);
      umsa_modem_model_inst.set_pins(seed[3:0]);
      repeat (6) @(posedge mclk);
      if (!modemLoopback)
        upd(seed[3:0]);
      modemLoopback <= seed[4];
      modemLineControl <= seed[8:5];
      repeat (6) @(posedge mclk);
      upd(seed[4] ? {seed[8], seed[7], seed[5], seed[6]} : seed[3:0]);
      wr(MSR_ADDR, 32'hff);
      rd(MSR_ADDR);
      chk("status", {24'h0, lvl, flg}, d);
      flg = 4'h0;
      rd(MSR_ADDR);
      chk("status reread", {24'h0, lvl, flg}, d);
    end
    wr(ACR_ADDR, 32'h6);
    rd(ACR_ADDR);
    chk("control", 32'h6, d);
    wr(ACR_ADDR, 32'h7);
    rd(ACR_ADDR);
    chk("run bit", 32'h7, d);
    wr(ACR_ADDR, 32'h6);
    rd(ACR_ADDR);
    chk("stopped", 32'h6, d);
    wr(ACR_ADDR, 32'h3);
    fork
      umsa_modem_model_inst.rx_pulse(4800, 0);
    join_none
    repeat (100) @(negedge mclk);
    chk("measuring", 32'h1, {31'h0, rateMeasuring});
    wait_div(6000);
    repeat (2) @(negedge mclk);
    chk("done flag", 32'h1, {31'h0, rateDoneIrq});
    rd(ACR_ADDR);
    chk("run cleared", 32'h2, d);
    chk("measuring off", 32'h0, {31'h0, rateMeasuring});
    chk("timeout flag", 32'h0, {31'h0, rateTimeoutIrq});
    wr(ACR_ADDR, 32'h202);
    @(negedge mclk);
    chk("done kept", 32'h1, {31'h0, rateDoneIrq});
    wr(ACR_ADDR, 32'h102);
    @(negedge mclk);
    chk("done cleared", 32'h0, {31'h0, rateDoneIrq});
    @(posedge mclk);
    rateDoneIrqEn <= 1'b0;
    wr(ACR_ADDR, 32'h1);
    fork
      umsa_modem_model_inst.rx_pulse(1600, 3200);
    join_none
    wait_div(8000);
    repeat (3) @(negedge mclk);
    chk("done masked", 32'h0, {31'h0, rateDoneIrq});
    report_and_stop();
  end
endmodule : testbench
